// >>> serial_command_link_frontend.sv
// Purpose: serial command front-end: line port, mode entry, echo, ack, watchdog
// Assumes: one clock, synchronous active-high reset
// Notes: command parsing is outside; it reports via cmd_* strobes
// What this block does
// - Line runs 9600 baud, 7 data bits, even parity, one stop bit.
// - No flow control; receive always, transmit whenever needed.
// - After reset send an identity banner then one hardware code letter.
// - With encoder present, listen about 100 ms for Z to enter firmware loading.
// - In logging mode, ten carriage returns in a row enter serial mode.
// - Entering by carriage returns sends OK.
// - Entering by carriage returns forces the watchdog on.
// - After reset return to the configured mode, even after carriage-return entry.
// - Logging mode streams a log character every 8 ms, string every 200 ms.
// - Log streaming never blocks carriage-return detection.
// - Serial default mode starts in serial mode and sends OK.
// - In serial mode echo each valid received character.
// - Send plus after a good command with no reply.
// - A query's reply stands in place of the plus.
// - Send minus after a malformed command.
// - Watchdog: one silent second stops motors and sends W.
// - During timeout keep working and resend W each second.
// - Any valid received character restarts the watchdog.
// - Otherwise watchdog enable follows the stored mode parameter.
// - Commands execute only on the terminating carriage return.
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"
module serial_command_link_frontend
	import serial_link_pkg::*;
#(
	parameter int unsigned MS_CYC = `MS_CYC,
	parameter int unsigned BIT_CYC = `BIT_CYC
) (
	input wire logic clk_sys, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic rxd, // Line receive data
	output logic txd, // Line transmit data
	input wire logic serial_default, // Configured mode is serial
	input wire logic wdog_cfg_en, // Stored parameter enables watchdog
	input wire logic encoder_present, // Encoder module fitted
	input wire logic [6:0] log_char, // Current logging character
	output logic [4:0] log_index, // Logging character position
	output logic cmd_valid, // Received character valid (pulse)
	output logic [6:0] cmd_char, // Received command character
	output logic cmd_line_end, // Character was the terminating CR
	input wire logic cmd_ok, // Parser: good command, no reply
	input wire logic cmd_err, // Parser: bad command
	input wire logic reply_valid, // Parser reply character valid
	input wire logic [6:0] reply_char, // Parser reply character
	output logic reply_ready, // Reply character accepted
	output logic serial_mode, // In serial command mode
	output logic firmware_load_mode, // Encoder loader mode
	output logic motor_stop, // Motors halted by watchdog
	output logic wdog_active // Watchdog armed
);
	localparam int WD_CYC = `WDOG_S * 1000;
	localparam int BANNER_LEN = 6;
	function automatic logic par7(input char_t c);
		return ^c;
	endfunction
	// ************************************************
	// Receiver
	// ************************************************
	logic [1:0] rs_r, rs_nxt;
	logic [13:0] rcnt_r, rcnt_nxt;
	logic [3:0] rbit_r, rbit_nxt;
	logic [8:0] rsh_r, rsh_nxt;
	rx_char_s rxo_r, rxo_nxt;
	logic rx_stb_r, rx_stb_nxt;
	always_comb begin
		rs_nxt = rs_r; rcnt_nxt = rcnt_r; rbit_nxt = rbit_r; rsh_nxt = rsh_r;
		rxo_nxt = rxo_r; rx_stb_nxt = 1'b0;
		case (rs_r)
			2'd0: if (!rxd) begin
				rs_nxt = 2'd1; rcnt_nxt = 14'(BIT_CYC / 2); rbit_nxt = 4'h0;
			end
			2'd1: if (rcnt_r == 14'h0) begin
				rcnt_nxt = 14'(BIT_CYC - 1);
				if (rbit_r == 4'h0 && rxd) rs_nxt = 2'd0;
				else if (rbit_r == 4'h9) begin
					// Parity and stop checked; bad characters dropped
					// Eight bits shifted in from the top: data in [7:1], parity in [8]
					rxo_nxt.ch = rsh_r[7:1];
					rxo_nxt.ok = rxd && (par7(rsh_r[7:1]) == rsh_r[8]);
					rx_stb_nxt = 1'b1;
					rs_nxt = 2'd0;
				end else begin
					if (rbit_r != 4'h0) rsh_nxt = {rxd, rsh_r[8:1]};
					rbit_nxt = rbit_r + 4'h1;
				end
			end else rcnt_nxt = rcnt_r - 14'h1;
			default: rs_nxt = 2'd0;
		endcase
	end
	// ************************************************
	// Two-entry transmit buffer
	// ************************************************
	char_t buf_r [2], buf_nxt [2];
	logic [1:0] cnt_r, cnt_nxt;
	logic push;
	char_t push_ch;
	logic tx_take;
	logic buf_ready;
	assign buf_ready = cnt_r != 2'd2;
	always_comb begin
		buf_nxt = buf_r; cnt_nxt = cnt_r;
		if (tx_take && cnt_r != 2'd0) begin
			buf_nxt[0] = buf_r[1]; cnt_nxt = cnt_nxt - 2'd1;
		end
		if (push && buf_ready) begin
			buf_nxt[cnt_nxt[0]] = push_ch; cnt_nxt = cnt_nxt + 2'd1;
		end
	end
	// ************************************************
	// Transmitter
	// ************************************************
	logic [13:0] tcnt_r, tcnt_nxt;
	logic [3:0] tbit_r, tbit_nxt;
	logic [9:0] tsh_r, tsh_nxt;
	logic tbusy_r, tbusy_nxt;
	always_comb begin
		tcnt_nxt = tcnt_r; tbit_nxt = tbit_r; tsh_nxt = tsh_r; tbusy_nxt = tbusy_r;
		tx_take = 1'b0;
		if (!tbusy_r) begin
			if (cnt_r != 2'd0) begin
				// Start, 7 data, even parity, stop
				tsh_nxt = {1'b1, par7(buf_r[0]), buf_r[0], 1'b0};
				tbusy_nxt = 1'b1; tbit_nxt = 4'h0; tcnt_nxt = 14'(BIT_CYC - 1); tx_take = 1'b1;
			end
		end else if (tcnt_r == 14'h0) begin
			tcnt_nxt = 14'(BIT_CYC - 1);
			tsh_nxt = {1'b1, tsh_r[9:1]};
			tbit_nxt = tbit_r + 4'h1;
			if (tbit_r == 4'h9) tbusy_nxt = 1'b0;
		end else tcnt_nxt = tcnt_r - 14'h1;
	end
	// ************************************************
	// Mode control, message sources and watchdog
	// ************************************************
	mode_e mode_r, mode_nxt;
	logic [2:0] msg_r, msg_nxt; // Pending message: 0 none,1 OK,2 plus,3 minus,4 W
	logic [2:0] mpos_r, mpos_nxt;
	logic [3:0] crn_r, crn_nxt;
	logic [31:0] tick_r, tick_nxt;
	logic [10:0] ms_r, ms_nxt;
	logic [7:0] lms_r, lms_nxt;
	logic [4:0] lidx_r, lidx_nxt;
	logic wd_force_r, wd_force_nxt;
	logic stop_r, stop_nxt;
	logic [6:0] echo_r, echo_nxt;
	logic echo_p_r, echo_p_nxt;
	logic good;
	logic ms_tick;
	assign good = rx_stb_r && rxo_r.ok;
	assign ms_tick = tick_r == 32'(MS_CYC - 1);
	function automatic char_t banner(input logic [2:0] i);
		case (i)
			3'd0: return 7'h46; // Arbitrary identity text
			3'd1: return 7'h57;
			3'd2: return 7'h31;
			3'd3: return `CH_CR;
			3'd4: return `CH_LF;
			default: return `CH_HW; // Arbitrary hardware code
		endcase
	endfunction
	always_comb begin
		mode_nxt = mode_r; msg_nxt = msg_r; mpos_nxt = mpos_r; crn_nxt = crn_r;
		tick_nxt = ms_tick ? 32'h0 : tick_r + 32'h1;
		ms_nxt = ms_r; lms_nxt = lms_r; lidx_nxt = lidx_r;
		wd_force_nxt = wd_force_r; stop_nxt = stop_r;
		echo_nxt = echo_r; echo_p_nxt = echo_p_r;
		push = 1'b0; push_ch = 7'h00; reply_ready = 1'b0;
		if (ms_tick) ms_nxt = ms_r + 11'h1;
		if (mode_r == MODE_BOOT) begin
			// Banner, then optional listen window for Z
			if (mpos_r < 3'(BANNER_LEN)) begin
				push = 1'b1; push_ch = banner(mpos_r);
				if (buf_ready) begin
					mpos_nxt = mpos_r + 3'h1; ms_nxt = 11'h0;
				end
			end else if (encoder_present && good && rxo_r.ch == `CH_Z) begin
				mode_nxt = MODE_LOAD;
			end else if (!encoder_present || ms_r >= 11'(`LISTEN_MS)) begin
				// Configured mode restored at every reset
				mode_nxt = serial_default ? MODE_SERIAL : MODE_LOG;
				msg_nxt = serial_default ? 3'd1 : 3'd0;
				mpos_nxt = 3'h0; ms_nxt = 11'h0; lms_nxt = 8'h0; lidx_nxt = 5'h0;
			end
		end else if (mode_r == MODE_LOG) begin
			// Receiver watched independently of logging output
			if (good) crn_nxt = (rxo_r.ch == `CH_CR) ? crn_r + 4'h1 : 4'h0;
			if (crn_r == 4'(`CR_RUN)) begin
				mode_nxt = MODE_SERIAL; msg_nxt = 3'd1; mpos_nxt = 3'h0;
				wd_force_nxt = 1'b1;
				ms_nxt = 11'h0;
			end else begin
				if (ms_tick) lms_nxt = lms_r + 8'h1;
				if (lms_r >= 8'(`LOG_CHAR_MS) && buf_ready) begin
					// One character per 8 ms, string restarts every 200 ms
					push = 1'b1; push_ch = log_char; lms_nxt = 8'h0;
					lidx_nxt = (lidx_r == 5'(`LOG_LEN - 1)) ? 5'h0 : lidx_r + 5'h1;
				end
			end
		end else if (mode_r == MODE_SERIAL) begin
			if (good) begin
				echo_nxt = rxo_r.ch; echo_p_nxt = 1'b1;
				ms_nxt = 11'h0; stop_nxt = 1'b0;
			end
			if (cmd_ok && msg_r == 3'd0) msg_nxt = 3'd2;
			if (cmd_err && msg_r == 3'd0) msg_nxt = 3'd3;
			if (wdog_active && ms_r >= 11'(WD_CYC) && msg_r == 3'd0) begin
				// Stop and W, repeated every second
				stop_nxt = 1'b1; msg_nxt = 3'd4; ms_nxt = 11'h0;
			end
			if (echo_p_r) begin
				push = 1'b1; push_ch = echo_r;
				if (buf_ready) echo_p_nxt = good;
			end else if (msg_r != 3'd0) begin
				push = 1'b1;
				case (msg_r)
					3'd1: push_ch = (mpos_r == 3'h0) ? `CH_OK_O : `CH_OK_K;
					3'd2: push_ch = `CH_PLUS;
					3'd3: push_ch = `CH_MINUS;
					default: push_ch = `CH_W;
				endcase
				if (buf_ready) begin
					if (msg_r == 3'd1 && mpos_r == 3'h0) mpos_nxt = 3'h1;
					else begin
						msg_nxt = 3'd0; mpos_nxt = 3'h0;
					end
				end
			end else if (reply_valid) begin
				// Query reply stands as the acknowledgement
				push = 1'b1; push_ch = reply_char; reply_ready = buf_ready;
			end
		end
	end
	assign cmd_valid = mode_r == MODE_SERIAL && good;
	assign cmd_char = rxo_r.ch;
	assign cmd_line_end = rxo_r.ch == `CH_CR; // Parser executes on this
	assign serial_mode = mode_r == MODE_SERIAL;
	assign firmware_load_mode = mode_r == MODE_LOAD;
	assign motor_stop = stop_r;
	assign wdog_active = wd_force_r | wdog_cfg_en;
	assign log_index = lidx_r;
	assign txd = tbusy_r ? tsh_r[0] : 1'b1;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rs_r <= 2'd0; rcnt_r <= 14'h0; rbit_r <= 4'h0; rsh_r <= 9'h0;
			rxo_r <= '0; rx_stb_r <= 1'b0;
			buf_r[0] <= 7'h00; buf_r[1] <= 7'h00; cnt_r <= 2'd0;
			tcnt_r <= 14'h0; tbit_r <= 4'h0; tsh_r <= 10'h3ff; tbusy_r <= 1'b0;
			mode_r <= MODE_BOOT; msg_r <= 3'd0; mpos_r <= 3'h0; crn_r <= 4'h0;
			tick_r <= 32'h0; ms_r <= 11'h0; lms_r <= 8'h0; lidx_r <= 5'h0;
			wd_force_r <= 1'b0; stop_r <= 1'b0; echo_r <= 7'h00; echo_p_r <= 1'b0;
		end else begin
			rs_r <= rs_nxt; rcnt_r <= rcnt_nxt; rbit_r <= rbit_nxt; rsh_r <= rsh_nxt;
			rxo_r <= rxo_nxt; rx_stb_r <= rx_stb_nxt;
			buf_r <= buf_nxt; cnt_r <= cnt_nxt;
			tcnt_r <= tcnt_nxt; tbit_r <= tbit_nxt; tsh_r <= tsh_nxt; tbusy_r <= tbusy_nxt;
			mode_r <= mode_nxt; msg_r <= msg_nxt; mpos_r <= mpos_nxt; crn_r <= crn_nxt;
			tick_r <= tick_nxt; ms_r <= ms_nxt; lms_r <= lms_nxt; lidx_r <= lidx_nxt;
			wd_force_r <= wd_force_nxt; stop_r <= stop_nxt; echo_r <= echo_nxt; echo_p_r <= echo_p_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> serial_link_cfg.svh
// Purpose: constants for the serial command front-end
// Assumes: 125 MHz system clock
// Notes: timing counts derive from the printed times
`ifndef SERIAL_LINK_CFG_SVH
`define SERIAL_LINK_CFG_SVH
`define CLK_HZ 125000000
`define BAUD_RATE 9600
`define BIT_CYC (`CLK_HZ / `BAUD_RATE)
`define DATA_BITS 7
`define CR_RUN 10
`define LISTEN_MS 100
`define LOG_CHAR_MS 8
`define LOG_STR_MS 200
`define WDOG_S 1
`define MS_CYC (`CLK_HZ / 1000)
`define CH_CR 7'h0d
`define CH_LF 7'h0a
`define CH_OK_O 7'h4f
`define CH_OK_K 7'h4b
`define CH_PLUS 7'h2b
`define CH_MINUS 7'h2d
`define CH_W 7'h57
`define CH_Z 7'h5a
`define CH_HW 7'h68
`define LOG_LEN 25
`endif

// >>> serial_link_pkg.sv
// Purpose: types for the serial command front-end
// Assumes: nothing
// Notes: none
package serial_link_pkg;
	typedef logic [6:0] char_t;
	typedef struct packed {
		logic ok;
		char_t ch;
	} rx_char_s;
	typedef enum logic [1:0] {
		MODE_BOOT = 2'b00,
		MODE_LOG = 2'b01,
		MODE_SERIAL = 2'b10,
		MODE_LOAD = 2'b11
	} mode_e;
endpackage

// >>> serial_link_assertions.sv
// Purpose: port-level checks of the serial command front-end
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"
module serial_link_assertions
	import serial_link_pkg::*;
#(
	parameter int unsigned MS_CYC = 125000
) (
	input wire logic clk_sys, // Clock
	input wire logic reset, // Reset
	input wire logic txd, // Line out
	input wire logic serial_default, // Configured mode
	input wire logic encoder_present, // Encoder fitted
	input wire logic [4:0] log_index, // Log position
	input wire logic cmd_valid, // Char strobe
	input wire logic [6:0] cmd_char, // Char
	input wire logic cmd_line_end, // CR flag
	input wire logic serial_mode, // Serial mode
	input wire logic firmware_load_mode, // Loader mode
	input wire logic motor_stop, // Motors halted
	input wire logic wdog_active // Watchdog armed
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_RESET_QUIET: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset |=> (txd && !serial_mode && !motor_stop && !cmd_valid)) else $error("not quiet in reset");
	AST_CMD_ONE: assert property (cmd_valid |=> !cmd_valid) else $error("strobe too long");
	AST_CMD_SERIAL: assert property (cmd_valid |-> serial_mode) else $error("strobe outside serial");
	AST_CR_END: assert property (cmd_valid |-> (cmd_line_end == (cmd_char == `CH_CR))) else $error("bad CR flag");
	AST_STOP_WDOG: assert property (motor_stop |-> wdog_active) else $error("stop without watchdog");
	AST_LOAD_ENC: assert property ($rose(firmware_load_mode) |-> encoder_present) else $error("loader no encoder");
	AST_FORCE_WDOG: assert property ($rose(serial_mode) && !serial_default |-> ##[0:2] wdog_active)
		else $error("watchdog not forced");
	AST_LOG_RANGE: assert property (log_index < `LOG_LEN) else $error("log index range");
	AST_LOG_STEP: assert property ($changed(log_index) && log_index != 5'h00 |->
		log_index == $past(log_index) + 5'h01) else $error("log index skip");
	COV_CMD: cover property (cmd_valid);
	COV_ENTRY: cover property ($rose(serial_mode) && !serial_default);
	COV_STOP: cover property ($rose(motor_stop));
endmodule
`default_nettype wire

// >>> host_uart_model.sv
// Purpose: host side of the line: sends and collects characters
// Assumes: fixed 7E1 framing at the design's bit time
// Notes: bad parity is sent only when a test asks for it
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"
module host_uart_model
	import serial_link_pkg::*;
#(
	parameter int BC = `BIT_CYC
) (
	input wire logic clk_sys, // Clock
	input wire logic txd, // Device line out
	output logic rxd // Device line in
);
	char_t rx_q[$];
	int frame_errs = 0;
	logic [8:0] d;
	initial rxd = 1'b1;
	// Host matches the fixed format and never waits for leave to send
	task automatic send(input char_t c, input logic bad);
		logic [9:0] bits;
		bits = {1'b1, (^c) ^ bad, c, 1'b0};
		@(posedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			#1 rxd = bits[i];
			repeat (BC) @(posedge clk_sys);
		end
	endtask
	initial forever begin
		@(negedge txd);
		repeat (BC / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BC) @(posedge clk_sys);
			d[i] = txd;
		end
		// Stop bit sampled mid-bit so a back-to-back start is not missed
		repeat (BC) @(posedge clk_sys);
		if (!txd || ^d[7:0]) frame_errs++;
		else rx_q.push_back(d[6:0]);
	end
endmodule
`default_nettype wire

// >>> serial_command_link_frontend_tb.sv
// Purpose: self-checking bench for the serial command front-end
// Assumes: MS_CYC shortened to 20 cycles, bit time to 16 cycles
// Notes: shortened timing keeps the run short
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"
module serial_command_link_frontend_tb;
	import serial_link_pkg::*;
	localparam int BIT = 16;
	logic clk_sys, reset, serial_default, wdog_cfg_en, cmd_ok, cmd_err, reply_valid, encoder_present;
	char_t reply_char, c, last_cmd;
	wire rxd, txd, cmd_valid, cmd_line_end, reply_ready, serial_mode, firmware_load_mode, motor_stop, wdog_active;
	wire [4:0] log_index;
	wire [6:0] cmd_char;
	wire [6:0] log_char;
	int errors = 0, n_compared = 0, n_cmd = 0, k;
	assign log_char = {2'b01, log_index};
	serial_command_link_frontend #(.MS_CYC(20), .BIT_CYC(BIT)) serial_command_link_frontend_i (.clk_sys(clk_sys),
		.reset(reset), .rxd(rxd), .txd(txd), .serial_default(serial_default), .wdog_cfg_en(wdog_cfg_en),
		.encoder_present(encoder_present),
		.log_char(log_char), .log_index(log_index), .cmd_valid(cmd_valid), .cmd_char(cmd_char),
		.cmd_line_end(cmd_line_end), .cmd_ok(cmd_ok), .cmd_err(cmd_err), .reply_valid(reply_valid),
		.reply_char(reply_char), .reply_ready(reply_ready), .serial_mode(serial_mode),
		.firmware_load_mode(firmware_load_mode), .motor_stop(motor_stop), .wdog_active(wdog_active));
	host_uart_model #(.BC(BIT)) host_uart_model_i (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (cmd_valid === 1'b1) begin
		last_cmd <= cmd_char;
		n_cmd <= n_cmd + 1;
	end
	task check(input logic [6:0] seen, input logic [6:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	task get_char(output char_t ch);
		k = 0;
		while (host_uart_model_i.rx_q.size() == 0 && k < 30000) begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 30000) errors++;
		ch = (k < 30000) ? host_uart_model_i.rx_q.pop_front() : 'x;
	endtask
	task do_reset(input logic def);
		#1 serial_default = def;
		reset = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1 reset = 1'b0;
	endtask
	task parser_pulse(input logic ok);
		@(posedge clk_sys);
		#1 {cmd_ok, cmd_err} = {ok, !ok};
		@(posedge clk_sys);
		#1 {cmd_ok, cmd_err} = 2'b00;
	endtask
	task test_serial_default;
		do_reset(1'b1);
		for (int i = 0; i < 6; i++) get_char(c);
		check(c, `CH_HW, "code letter");
		get_char(c);
		check(c, `CH_OK_O, "O");
		get_char(c);
		check(c, `CH_OK_K, "K");
		check(serial_mode, 7'h01, "mode");
		$display("test_serial_default done");
	endtask
	task test_echo_ack;
		host_uart_model_i.send(7'h41, 1'b0);
		get_char(c);
		check(c, 7'h41, "echo");
		check(last_cmd, 7'h41, "cmd char");
		parser_pulse(1'b0);
		get_char(c);
		check(c, `CH_MINUS, "minus");
		host_uart_model_i.send(7'h41, 1'b0);
		get_char(c);
		parser_pulse(1'b1);
		get_char(c);
		check(c, `CH_PLUS, "plus");
		k = n_cmd;
		host_uart_model_i.send(7'h42, 1'b1);
		repeat (3 * BIT) @(posedge clk_sys);
		check(7'(n_cmd - k), 7'h00, "bad char taken");
		check(7'(host_uart_model_i.rx_q.size()), 7'h00, "bad char echoed");
		host_uart_model_i.send(7'h3f, 1'b0);
		get_char(c);
		#1 {reply_valid, reply_char} = {1'b1, 7'h35};
		do @(posedge clk_sys); while (reply_ready !== 1'b1);
		#1 reply_valid = 1'b0;
		get_char(c);
		check(c, 7'h35, "reply");
		repeat (15 * BIT) @(posedge clk_sys);
		check(7'(host_uart_model_i.rx_q.size()), 7'h00, "extra ack");
		$display("test_echo_ack done");
	endtask
	task test_cr_entry;
		do_reset(1'b0);
		// Carriage returns only count once the banner is out
		for (int i = 0; i < 6; i++) get_char(c);
		check(c, `CH_HW, "code letter");
		for (int i = 0; i < 9; i++) host_uart_model_i.send(`CH_CR, 1'b0);
		check(serial_mode, 7'h00, "early entry");
		host_uart_model_i.send(`CH_CR, 1'b0);
		check(serial_mode, 7'h01, "entry");
		check(wdog_active, 7'h01, "forced watchdog");
		for (int i = 0; i < 7; i++) get_char(c);
		check(c & 7'h60, 7'h20, "log char");
		for (int i = 0; i < 60 && c !== `CH_OK_O; i++) get_char(c);
		get_char(c);
		check(c, `CH_OK_K, "OK after entry");
		$display("test_cr_entry done");
	endtask
	task test_watchdog;
		host_uart_model_i.rx_q.delete();
		k = 0;
		while (motor_stop !== 1'b1 && k < 30000) begin
			@(posedge clk_sys);
			k++;
		end
		check(motor_stop, 7'h01, "no stop");
		get_char(c);
		check(c, `CH_W, "W");
		get_char(c);
		check(c, `CH_W, "W repeat");
		host_uart_model_i.send(7'h00, 1'b0);
		repeat (4) @(posedge clk_sys);
		check(motor_stop, 7'h00, "no restart");
		get_char(c);
		check(c, 7'h00, "echo of control code");
		$display("test_watchdog done");
	endtask
	task test_loader;
		encoder_present = 1'b1;
		do_reset(1'b0);
		host_uart_model_i.rx_q.delete();
		for (int i = 0; i < 6; i++) get_char(c);
		check(firmware_load_mode, 7'h00, "early loader");
		host_uart_model_i.send(`CH_Z, 1'b0);
		repeat (4) @(posedge clk_sys);
		check(firmware_load_mode, 7'h01, "loader entry");
		$display("test_loader done");
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{reset, serial_default, wdog_cfg_en, cmd_ok, cmd_err, reply_valid, reply_char} = {6'h20, 7'h00};
		encoder_present = 1'b0;
		test_serial_default();
		test_echo_ack();
		test_cr_entry();
		test_watchdog();
		test_loader();
		check(7'(host_uart_model_i.frame_errs), 7'h00, "frame errors");
		give_verdict();
	end
	initial begin
		repeat (90000) @(posedge clk_sys);
		errors++;
		give_verdict();
	end
endmodule
bind serial_command_link_frontend serial_link_assertions #(.MS_CYC(MS_CYC)) serial_link_assertions_i (
	.clk_sys(clk_sys), .reset(reset), .txd(txd), .serial_default(serial_default),
	.encoder_present(encoder_present), .log_index(log_index), .cmd_valid(cmd_valid), .cmd_char(cmd_char),
	.cmd_line_end(cmd_line_end), .serial_mode(serial_mode), .firmware_load_mode(firmware_load_mode),
	.motor_stop(motor_stop), .wdog_active(wdog_active));
`default_nettype wire
